/* rtl/ccs_pkg.sv */
package ccs_pkg;

  // Serial addresses, write and read forms
  localparam logic [7:0] WR_ADDR   = 8'hD2;
  localparam logic [7:0] RD_ADDR   = 8'hD3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int         NUM_REGS  = 3;
  localparam logic [2:0] IDX_MAX   = 3'h7;

  // Power-up contents; reads past the implemented bytes return the fill
  localparam logic [7:0] REG0_RST  = 8'h00;
  localparam logic [7:0] REG1_RST  = 8'hFF;
  localparam logic [7:0] REG2_RST  = 8'hFF;
  localparam logic [7:0] READ_FILL = 8'hFF;

  // Field positions of frequency_spread_control
  localparam int R0_TRISTATE    = 0;
  localparam int R0_SPREAD_EN   = 1;
  localparam int R0_SOFT_MSB    = 2;
  localparam int R0_SOFT_SEL    = 3;
  localparam int R0_SOFT_LO     = 4;
  localparam int R0_SPREAD_WIDE = 7;

  // Field positions of host_clock_enables and bus_clock_enables
  localparam int R1_FREE_HOST = 0;
  localparam int R1_HOST_A    = 1;
  localparam int R1_HOST_B    = 2;
  localparam int R1_FREE_MEM  = 3;
  localparam int R2_FREE_BUS  = 6;

  // Gate slots; slots below N_HOST_SRC follow the host source
  localparam int G_FREE_HOST = 0;
  localparam int G_HOST_A    = 1;
  localparam int G_HOST_B    = 2;
  localparam int G_FREE_MEM  = 3;
  localparam int G_IRQ       = 4;
  localparam int G_MEM       = 5;
  localparam int G_FREE_BUS  = 6;
  localparam int G_BUS0      = 7;
  localparam int N_BUS       = 6;
  localparam int N_HOST_SRC  = 6;
  localparam int N_GATES     = 13;

  // Cycles after reset release before the straps are taken
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_CMD   = 3'b010,
    ST_COUNT = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101
  } ccs_i2c_state_t;

  typedef enum logic [1:0] {
    DIV2 = 2'b00,
    DIV3 = 2'b01,
    DIV4 = 2'b10
  } ccs_div_t;

  // Host frequency in tenths of MHz, indexed by the frequency code
  localparam logic [11:0] HOST_TENTHS [16] = '{
    12'h4D8, 12'h2EE, 12'h341, 12'h29C, 12'h406, 12'h460, 12'h532, 12'h3EB,
    12'h4B0, 12'h47E, 12'h44C, 12'h41A, 12'h578, 12'h5DC, 12'h4D8, 12'h532};

  // Bus divider for the same code
  localparam ccs_div_t BUS_DIV [16] = '{
    DIV3, DIV2, DIV2, DIV2, DIV3, DIV3, DIV3, DIV3,
    DIV3, DIV3, DIV3, DIV3, DIV4, DIV4, DIV4, DIV4};

  // Host half-periods per bus high phase
  function automatic logic [2:0] div_half(input ccs_div_t d);
    unique case (d)
      DIV2:    div_half = 3'h2;
      DIV3:    div_half = 3'h3;
      DIV4:    div_half = 3'h4;
      default: div_half = 3'h3;
    endcase
  endfunction

endpackage

/* rtl/ccs_clock_gate.sv */
`timescale 1ns/10ps
// Stops or starts one clock only after a bus rise and then a fall of its own source
module ccs_clock_gate (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Source and control
  input  wire logic src,
  input  wire logic bus_rise,
  input  wire logic want,
  // Gated clock
  output logic      out
);

  logic src_d;
  logic armed;
  logic active;
  logic next_active;

  // Delayed source for fall detection
  always_ff @(posedge clock)
  begin
    if (!rst_n) src_d <= 1'b0;
    else        src_d <= src;
  end

  // Armed by a free bus rise while a change is pending
  always_ff @(posedge clock)
  begin
    if (!rst_n)                armed <= 1'b0;
    else if (want == active)   armed <= 1'b0;
    else if (bus_rise)         armed <= 1'b1; // RQ8
  end

  // Change only on a source fall, so a high phase is never cut short
  assign next_active = (armed && src_d && !src) ? want : active; // RQ8

  always_ff @(posedge clock)
  begin
    if (!rst_n) active <= 1'b0;
    else        active <= next_active;
  end

  // Stopped clock sits low
  always_ff @(posedge clock)
  begin
    if (!rst_n) out <= 1'b0;
    else        out <= src & next_active; // RQ7
  end

  a_stop_no_cut: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
    $fell(out) |-> !$past(src))
    else $error("gated clock fell while source was high");

  a_change_sync: assert property (@(posedge clock) disable iff (!rst_n) // RQ8
    (active != $past(active)) |-> $past(armed) && $past(src_d) && !$past(src))
    else $error("gate changed outside the bus-rise then fall window");

endmodule

/* rtl/ccs_clock_synth_ctrl.sv */
`timescale 1ns/10ps
// Functional notes
// RQ1: Code picks host frequency and bus divider
// RQ2: Mode strap latched; selects halt input or reference
// RQ3: Mode one disables both halt inputs
// RQ4: Output runs when enable bit and halt agree
// RQ5: Controller waits 3 ms before enabling outputs; clocks_oe is high from reset, with no wait timer
// RQ6: Host halt stops host, irq, memory; bus halt
// RQ7: Stopped clocks low, final high never shortened
// RQ8: Change after bus rise, then clock's fall
// RQ9: Serial slave with register read-back
// RQ10: Controller sends all preceding bytes to reach one
// RQ11: Registers load defaults at power-up
// RQ12: Write opens with start and write address
// RQ13: Command and count bytes acked, ignored
// RQ14: Each received byte acknowledged by pulling data low
// RQ15: Data bytes fill registers in order until stop
// RQ16: Read address returns registers from zero upward
// RQ17: Register zero bit three selects software code
// RQ18: Spread enable and depth bits
// RQ19: Tristate bit floats every clock output
// RQ20: Host enables in register one, reset ones
// RQ21: Bus enables in register two, reset ones
// RQ22: Frequency straps sampled once after power-up
// RQ23: Free host clock ignores host halt
// RQ24: Foreign address ignored, registers unchanged
module ccs_clock_synth_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Straps and halt pins
  input  wire logic        freq_code_bit0,
  input  wire logic        freq_code_bit1,
  input  wire logic        freq_code_bit2,
  input  wire logic        freq_code_bit3,
  input  wire logic        mode_strap,
  input  wire logic        host_halt_n,
  // Shared reference pin
  input  wire logic        ref_pin_in,
  output logic             reference_clock_out,
  output logic             ref_pin_oe,
  // Serial link
  input  wire logic        serial_clock_line,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  // Clock outputs
  output logic             free_host_clock,
  output logic             host_clock_a,
  output logic             host_clock_b,
  output logic             free_memory_clock,
  output logic             irq_ctrl_clock,
  output logic             memory_clocks,
  output logic             free_bus_clock,
  output logic [5:0]       bus_clocks,
  output logic             clocks_oe,
  // Synthesizer settings
  output logic [3:0]       freq_code,
  output logic [11:0]      host_freq_tenths,
  output ccs_pkg::ccs_div_t bus_divide,
  output logic             spread_enable,
  output logic             spread_wide
);

  localparam int NSYNC = 9;

  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [1:0]       strap_cnt;
  logic             strap_done;
  logic [3:0]       hw_code;
  logic             mode;
  logic [7:0]       reg0;
  logic [7:0]       reg1;
  logic [7:0]       reg2;
  logic [3:0]       next_code;
  logic             host_src;
  logic             ref_src;
  logic [2:0]       bus_cnt;
  logic             bus_src;
  logic             bus_src_d;
  logic             bus_rise;
  logic             host_run;
  logic             bus_run;
  logic [ccs_pkg::N_GATES-1:0] want;
  logic [ccs_pkg::N_GATES-1:0] src;
  logic [ccs_pkg::N_GATES-1:0] gated;
  logic             scl;
  logic             sda;
  logic             scl_d;
  logic             sda_d;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_cond;
  logic             stop_cond;
  ccs_pkg::ccs_i2c_state_t state;
  logic [3:0]       bitcnt;
  logic [7:0]       shreg;
  logic [7:0]       tx_sh;
  logic             ack_phase;
  logic             master_nack;
  logic [2:0]       idx;
  logic             byte_end;
  logic             wr_en;
  logic [7:0]       rd_byte;

  // Register read decode, shared by the loader and the checks
  function automatic logic [7:0] reg_read(input logic [2:0] i, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r2);
    unique case (i)
      3'h0:    reg_read = r0;
      3'h1:    reg_read = r1;
      3'h2:    reg_read = r2;
      default: reg_read = ccs_pkg::READ_FILL;
    endcase
  endfunction

  // Pins cross two flops before any logic looks at them
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1 <= '1;
      sync2 <= '1;
    end
    else
    begin
      sync1 <= {serial_data_line_in, serial_clock_line, ref_pin_in, host_halt_n, mode_strap,
                freq_code_bit3, freq_code_bit2, freq_code_bit1, freq_code_bit0};
      sync2 <= sync1;
    end
  end

  // Straps taken once, a few cycles after reset release
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      hw_code    <= 4'h0;
      mode       <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == ccs_pkg::STRAP_SETTLE)
      begin
        strap_done <= 1'b1;
        hw_code    <= sync2[3:0]; // RQ22
        mode       <= sync2[4]; // RQ2
      end
    end
  end

  // Hardware or software code into the shared table
  assign next_code = reg0[ccs_pkg::R0_SOFT_SEL] ?
    {reg0[ccs_pkg::R0_SOFT_MSB], reg0[ccs_pkg::R0_SOFT_LO+2:ccs_pkg::R0_SOFT_LO]} :
    hw_code; // RQ17

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      freq_code        <= 4'h0;
      host_freq_tenths <= ccs_pkg::HOST_TENTHS[0];
      bus_divide       <= ccs_pkg::BUS_DIV[0];
      spread_enable    <= 1'b0;
      spread_wide      <= 1'b0;
    end
    else
    begin
      freq_code        <= next_code;
      host_freq_tenths <= ccs_pkg::HOST_TENTHS[next_code]; // RQ1
      bus_divide       <= ccs_pkg::BUS_DIV[next_code]; // RQ1
      spread_enable    <= reg0[ccs_pkg::R0_SPREAD_EN]; // RQ18
      spread_wide      <= reg0[ccs_pkg::R0_SPREAD_WIDE]; // RQ18
    end
  end

  // Sources: host and reference at half rate, bus high for a divider's worth
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      host_src  <= 1'b0;
      ref_src   <= 1'b0;
      bus_cnt   <= 3'h0;
      bus_src   <= 1'b0;
      bus_src_d <= 1'b0;
    end
    else
    begin
      host_src  <= ~host_src;
      ref_src   <= ~ref_src;
      bus_src_d <= bus_src;
      if (bus_cnt + 3'h1 >= ccs_pkg::div_half(bus_divide))
      begin
        bus_cnt <= 3'h0;
        bus_src <= ~bus_src; // RQ1
      end
      else bus_cnt <= bus_cnt + 3'h1;
    end
  end

  assign bus_rise = bus_src & ~bus_src_d;

  // Halts count only in mode zero; the reference pin is the bus halt there
  assign host_run = mode | sync2[5]; // RQ3 RQ6
  assign bus_run  = mode | sync2[6]; // RQ2 RQ3 RQ6

  always_comb
  begin
    want = '0;
    src  = '0;
    want[ccs_pkg::G_FREE_HOST] = reg1[ccs_pkg::R1_FREE_HOST]; // RQ20 RQ23
    want[ccs_pkg::G_HOST_A]    = reg1[ccs_pkg::R1_HOST_A] & host_run; // RQ4 RQ6
    want[ccs_pkg::G_HOST_B]    = reg1[ccs_pkg::R1_HOST_B] & host_run; // RQ4 RQ6
    want[ccs_pkg::G_FREE_MEM]  = reg1[ccs_pkg::R1_FREE_MEM]; // RQ20
    want[ccs_pkg::G_IRQ]       = host_run; // RQ6
    want[ccs_pkg::G_MEM]       = host_run; // RQ6
    want[ccs_pkg::G_FREE_BUS]  = reg2[ccs_pkg::R2_FREE_BUS]; // RQ21
    for (int b = 0; b < ccs_pkg::N_BUS; b++)
      want[ccs_pkg::G_BUS0+b] = reg2[b] & bus_run; // RQ4 RQ21
    for (int g = 0; g < ccs_pkg::N_GATES; g++)
      src[g] = (g < ccs_pkg::N_HOST_SRC) ? host_src : bus_src;
  end

  // One glitch-free gate for every stoppable output
  for (genvar g = 0; g < ccs_pkg::N_GATES; g++)
  begin : gen_gate
    ccs_clock_gate u_gate (
      .clock    (clock),
      .rst_n    (rst_n),
      .src      (src[g]),
      .bus_rise (bus_rise),
      .want     (want[g]),
      .out      (gated[g])
    );
  end

  assign free_host_clock     = gated[ccs_pkg::G_FREE_HOST];
  assign host_clock_a        = gated[ccs_pkg::G_HOST_A];
  assign host_clock_b        = gated[ccs_pkg::G_HOST_B];
  assign free_memory_clock   = gated[ccs_pkg::G_FREE_MEM];
  assign irq_ctrl_clock      = gated[ccs_pkg::G_IRQ];
  assign memory_clocks       = gated[ccs_pkg::G_MEM];
  assign free_bus_clock      = gated[ccs_pkg::G_FREE_BUS];
  assign bus_clocks          = gated[ccs_pkg::G_BUS0 +: ccs_pkg::N_BUS];
  assign reference_clock_out = ref_src;
  assign clocks_oe           = ~reg0[ccs_pkg::R0_TRISTATE]; // RQ19
  assign ref_pin_oe          = mode & clocks_oe; // RQ2 RQ19

  // Serial line conditions, read from the second sync stage only
  assign scl        = sync2[7];
  assign sda        = sync2[8];
  assign scl_rise   = scl & ~scl_d;
  assign scl_fall   = ~scl & scl_d;
  assign start_cond = scl & scl_d & sda_d & ~sda;
  assign stop_cond  = scl & scl_d & ~sda_d & sda;
  assign byte_end   = scl_fall && !ack_phase && bitcnt == ccs_pkg::BYTE_BITS;
  assign wr_en      = byte_end && state == ccs_pkg::ST_WDATA && idx < 3'(ccs_pkg::NUM_REGS);
  assign serial_data_line_out = 1'b0;
  assign rd_byte    = reg_read(idx, reg0, reg1, reg2); // RQ9

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Slave sequencer: address, dummy command and count, then data
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= ccs_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx_sh <= 8'h00;
      ack_phase <= 1'b0;
      master_nack <= 1'b0;
      idx <= 3'h0;
      serial_data_line_oe <= 1'b0;
    end
    else if (start_cond)
    begin
      state <= ccs_pkg::ST_ADDR; // RQ12 RQ16
      bitcnt <= 4'h0;
      ack_phase <= 1'b0;
      idx <= 3'h0;
      serial_data_line_oe <= 1'b0;
    end
    else if (stop_cond)
    begin
      state <= ccs_pkg::ST_IDLE; // RQ15 RQ16
      serial_data_line_oe <= 1'b0;
    end
    else if (state != ccs_pkg::ST_IDLE)
    begin
      if (scl_rise && !ack_phase)
      begin
        shreg <= {shreg[6:0], sda};
        bitcnt <= bitcnt + 4'h1;
      end
      if (scl_rise && ack_phase)
        master_nack <= sda;
      if (byte_end)
      begin
        ack_phase <= 1'b1;
        serial_data_line_oe <= state != ccs_pkg::ST_RDATA; // RQ14 RQ13
        unique case (state)
          ccs_pkg::ST_ADDR:
          begin
            master_nack <= 1'b0;
            if (shreg == ccs_pkg::WR_ADDR)      state <= ccs_pkg::ST_CMD; // RQ12
            else if (shreg == ccs_pkg::RD_ADDR) state <= ccs_pkg::ST_RDATA; // RQ16 RQ9
            else
            begin
              state <= ccs_pkg::ST_IDLE; // RQ24
              serial_data_line_oe <= 1'b0;
            end
          end
          ccs_pkg::ST_CMD:   state <= ccs_pkg::ST_COUNT; // RQ13
          ccs_pkg::ST_COUNT: state <= ccs_pkg::ST_WDATA; // RQ13
          ccs_pkg::ST_WDATA: idx <= (idx == ccs_pkg::IDX_MAX) ? idx : idx + 3'h1; // RQ15
          ccs_pkg::ST_RDATA: idx <= idx;
          default:           state <= ccs_pkg::ST_IDLE;
        endcase
      end
      else if (scl_fall && ack_phase)
      begin
        ack_phase <= 1'b0;
        bitcnt <= 4'h0;
        if (state == ccs_pkg::ST_RDATA && !master_nack)
        begin
          tx_sh <= rd_byte; // RQ16 RQ9
          serial_data_line_oe <= ~rd_byte[7];
          idx <= (idx == ccs_pkg::IDX_MAX) ? idx : idx + 3'h1;
        end
        else
        begin
          serial_data_line_oe <= 1'b0;
          if (state == ccs_pkg::ST_RDATA) state <= ccs_pkg::ST_IDLE;
        end
      end
      else if (scl_fall && state == ccs_pkg::ST_RDATA && bitcnt != 4'h0)
      begin
        serial_data_line_oe <= ~tx_sh[6];
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // Control registers; bytes past the last one are acked and dropped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      reg0 <= ccs_pkg::REG0_RST; // RQ11 RQ19
      reg1 <= ccs_pkg::REG1_RST; // RQ11 RQ20
      reg2 <= ccs_pkg::REG2_RST; // RQ11 RQ21
    end
    else if (wr_en)
    begin
      if (idx == 3'h0) reg0 <= shreg; // RQ15
      if (idx == 3'h1) reg1 <= shreg; // RQ15
      if (idx == 3'h2) reg2 <= shreg; // RQ15
    end
  end

  sequence s_addr_done(logic [7:0] a);
    byte_end && state == ccs_pkg::ST_ADDR && shreg == a;
  endsequence

  a_write_ack: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
    s_addr_done(ccs_pkg::WR_ADDR) |=> serial_data_line_oe && state == ccs_pkg::ST_CMD)
    else $error("write address not acknowledged");

  a_foreign_addr: assert property (@(posedge clock) disable iff (!rst_n) // RQ24
    byte_end && state == ccs_pkg::ST_ADDR && shreg != ccs_pkg::WR_ADDR
    && shreg != ccs_pkg::RD_ADDR |=> !serial_data_line_oe && state == ccs_pkg::ST_IDLE
    && $stable(reg0) && $stable(reg1) && $stable(reg2))
    else $error("foreign address answered");

  a_store_order: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
    wr_en |=> reg_read($past(idx), reg0, reg1, reg2) == $past(shreg) && idx == $past(idx) + 3'h1)
    else $error("data byte not stored in order");

  a_read_first: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
    s_addr_done(ccs_pkg::RD_ADDR) ##[1:40] (scl_fall && ack_phase)
    |=> tx_sh == reg0 && idx == 3'h1)
    else $error("read-back did not start at register zero");

  a_reset_dflt: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
    !$past(rst_n) |-> reg0 == ccs_pkg::REG0_RST && reg1 == ccs_pkg::REG1_RST
    && reg2 == ccs_pkg::REG2_RST && !serial_data_line_oe)
    else $error("registers not at defaults after reset");

  a_halt_ignored: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
    mode |-> want[ccs_pkg::G_IRQ] && want[ccs_pkg::G_MEM])
    else $error("halt acted in mode one");

  a_enable_and: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
    !mode && !sync2[6] |-> want[ccs_pkg::G_BUS0 +: ccs_pkg::N_BUS] == '0
    && want[ccs_pkg::G_FREE_BUS] == reg2[ccs_pkg::R2_FREE_BUS])
    else $error("bus halt not combined with enables");

  a_free_host: assert property (@(posedge clock) disable iff (!rst_n) // RQ23
    !host_run |-> want[ccs_pkg::G_FREE_HOST] == reg1[ccs_pkg::R1_FREE_HOST]
    && !want[ccs_pkg::G_HOST_A] && !want[ccs_pkg::G_HOST_B])
    else $error("host halt misapplied");

  a_soft_code: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
    reg0[ccs_pkg::R0_SOFT_SEL] && $stable(reg0) |=> freq_code ==
    {$past(reg0[ccs_pkg::R0_SOFT_MSB]), $past(reg0[ccs_pkg::R0_SOFT_LO+2:ccs_pkg::R0_SOFT_LO])})
    else $error("software code not applied");

  a_tristate: assert property (@(posedge clock) disable iff (!rst_n) // RQ19
    wr_en && idx == 3'h0 && shreg[ccs_pkg::R0_TRISTATE] |=> !clocks_oe && !ref_pin_oe)
    else $error("tristate bit did not float outputs");

endmodule

/* dv/ccs_i2c_ctrl_model.sv */
`timescale 1ns/10ps
// Serial bus controller: drives the clock line, pulls data low and reports results
module ccs_i2c_ctrl_model (
  // Clock
  input  wire logic       clock,
  // Serial pins
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  // Result strobe
  output logic            res_valid,
  output logic            res_ack,
  output logic [7:0]      res_val
);
  // Ten cycles per level keeps us clear of the slave's two-flop pin synchroniser
  localparam int HALF = 10;

  // Bus idle: both lines released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_ack = 1'b0;
    res_val = 8'h00;
  end

  task automatic half();
    repeat (HALF) @(negedge clock);
  endtask

  // One strobe per result, so the bench sees each exactly once
  task automatic post(input logic ack, input logic [7:0] v);
    res_ack <= ack;
    res_val <= v;
    res_valid <= 1'b1;
    @(negedge clock);
    res_valid <= 1'b0;
  endtask

  // Data only changes while the clock line is low
  task automatic clk_bit(input logic drive_low, output logic seen);
    sda_low = drive_low;
    half();
    scl = 1'b1;
    half();
    seen = sda;
    scl = 1'b0;
  endtask

  // Works from idle and as a repeated start
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // Whole byte, most significant bit first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    post(1'b1, {7'h00, ~s});
  endtask

  // Controller acknowledges every byte but the last
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b0, d[i]);
    clk_bit(~last, s);
    post(1'b0, d);
  endtask
endmodule

/* dv/ccs_clock_synth_ctrl_tb_top.sv */
`timescale 1ns/10ps
// Straps, halts, serial traffic and clock activity against a shadow of the registers
module ccs_clock_synth_ctrl_tb_top;
  logic clock, rst_n, mode_strap, host_halt_n, bus_halt_n, reference_clock_out, ref_pin_oe;
  logic serial_data_line_oe, scl, sda_low, res_valid, res_ack, clocks_oe;
  logic free_host_clock, host_clock_a, host_clock_b, free_memory_clock, irq_ctrl_clock;
  logic memory_clocks, free_bus_clock, spread_enable, spread_wide;
  logic [5:0]        bus_clocks;
  logic [3:0]        straps, latched, freq_code;
  logic [11:0]       host_freq_tenths;
  logic [7:0]        res_val;
  logic [7:0]        wdat [4];
  logic [7:0]        regs [3];
  logic [8:0]        note;
  logic [8:0]        exp_q [$];
  ccs_pkg::ccs_div_t bus_divide;
  int                n_fail, n_compared;
  // Open-drain data line with pull-up; shared pin driven by the device in mode one
  wire sda = !(sda_low || serial_data_line_oe);
  wire ref_pin = ref_pin_oe ? reference_clock_out : bus_halt_n;

  ccs_clock_synth_ctrl u_ccs_clock_synth_ctrl (
    .clock(clock), .rst_n(rst_n), .freq_code_bit0(straps[0]), .freq_code_bit1(straps[1]),
    .freq_code_bit2(straps[2]), .freq_code_bit3(straps[3]), .mode_strap(mode_strap),
    .host_halt_n(host_halt_n), .ref_pin_in(ref_pin), .reference_clock_out(reference_clock_out),
    .ref_pin_oe(ref_pin_oe), .serial_clock_line(scl), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe(serial_data_line_oe),
    .free_host_clock(free_host_clock), .host_clock_a(host_clock_a),
    .host_clock_b(host_clock_b), .free_memory_clock(free_memory_clock),
    .irq_ctrl_clock(irq_ctrl_clock), .memory_clocks(memory_clocks),
    .free_bus_clock(free_bus_clock), .bus_clocks(bus_clocks), .clocks_oe(clocks_oe),
    .freq_code(freq_code), .host_freq_tenths(host_freq_tenths), .bus_divide(bus_divide),
    .spread_enable(spread_enable), .spread_wide(spread_wide));

  ccs_i2c_ctrl_model u_ccs_i2c_ctrl_model (
    .clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low),
    .res_valid(res_valid), .res_ack(res_ack), .res_val(res_val));

  // Free-running 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic tally(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (!ok)
    begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    tally(got === exp, {15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, {8'h00, got}, {8'h00, exp});
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    tally(got === exp, got, exp);
  endtask

  // Each controller result is matched with the oldest note
  always @(posedge clock)
  begin
    if (res_valid)
    begin
      if (exp_q.size() == 0)
        tally(1'b0, {7'h00, res_ack, res_val}, 16'h0000);
      else
      begin
        note = exp_q.pop_front();
        cmp_bit(res_ack, note[8]);
        if (res_ack)
          cmp_bit(res_val[0], note[0]);
        else
          cmp_byte(res_val, note[7:0]);
      end
    end
  end

  task automatic give_verdict();
    if (exp_q.size() != 0)
      n_fail++;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic ack);
    exp_q.push_back({1'b1, 7'h00, ack});
    u_ccs_i2c_ctrl_model.wbyte(b);
  endtask

  // Registers are only reachable by sending every byte before them
  task automatic write_regs(input logic [7:0] addr, input int n);
    u_ccs_i2c_ctrl_model.start();
    send(addr, addr == ccs_pkg::WR_ADDR);
    if (addr == ccs_pkg::WR_ADDR)
    begin
      send(8'($urandom), 1'b1);
      send(8'($urandom), 1'b1);
      for (int i = 0; i < n; i++)
      begin
        send(wdat[i], 1'b1);
        if (i < 3)
          regs[i] = wdat[i];
      end
    end
    u_ccs_i2c_ctrl_model.stop();
  endtask

  task automatic read_regs(input int n);
    u_ccs_i2c_ctrl_model.start();
    send(ccs_pkg::RD_ADDR, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back({1'b0, (i < 3) ? regs[i] : 8'hFF});
      u_ccs_i2c_ctrl_model.rbyte(i == n - 1);
    end
    u_ccs_i2c_ctrl_model.stop();
  endtask

  task automatic check_code(input logic [3:0] c);
    cmp_word({12'h000, freq_code}, {12'h000, c});
    cmp_word({4'h0, host_freq_tenths}, {4'h0, ccs_pkg::HOST_TENTHS[c]});
    cmp_word({14'h0000, bus_divide}, {14'h0000, ccs_pkg::BUS_DIV[c]});
  endtask

  // Which outputs ever go high over a window; gates need a bus rise and a fall first
  task automatic check_act();
    logic [13:0] hi, exp;
    logic        hh, bh;
    hi = 14'h0000;
    repeat (30) @(negedge clock);
    repeat (40)
    begin
      @(negedge clock);
      hi |= {reference_clock_out, bus_clocks, free_bus_clock, memory_clocks, irq_ctrl_clock,
             free_memory_clock, host_clock_b, host_clock_a, free_host_clock};
    end
    hh = mode_strap | host_halt_n;
    bh = mode_strap | bus_halt_n;
    exp = {1'b1, regs[2][5:0] & {6{bh}}, regs[2][6], hh, hh, regs[1][3], regs[1][2] & hh,
           regs[1][1] & hh, regs[1][0]};
    cmp_word({2'h0, hi}, {2'h0, exp});
  endtask

  // Settle time is kept short; nothing here depends on the oscillators
  task automatic reset(input logic mode);
    rst_n = 1'b0;
    mode_strap = mode;
    straps = 4'($urandom);
    host_halt_n = 1'b1;
    bus_halt_n = 1'b1;
    regs = '{8'h00, 8'hFF, 8'hFF};
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
    latched = straps;
    straps = ~straps;
    check_code(latched);
    cmp_bit(ref_pin_oe, mode);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(41121));
    n_fail = 0;
    n_compared = 0;
    rst_n = 1'b0;
    reset(1'b0);
    read_regs(4);
    check_act();
    for (int c = 0; c < 16; c++)
    begin
      wdat[0] = {1'($urandom), c[2:0], 1'b1, c[3], 1'($urandom), 1'b0};
      write_regs(ccs_pkg::WR_ADDR, 1);
      check_code(c[3:0]);
      cmp_bit(spread_enable, wdat[0][1]);
      cmp_bit(spread_wide, wdat[0][7]);
    end
    wdat[0] = 8'h01;
    write_regs(ccs_pkg::WR_ADDR, 1);
    cmp_bit(clocks_oe, 1'b0);
    check_code(latched);
    wdat[0] = 8'h00;
    write_regs(ccs_pkg::WR_ADDR, 1);
    cmp_bit(clocks_oe, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      wdat[0] = 8'($urandom) & 8'hFE;
      wdat[1] = 8'($urandom);
      wdat[2] = 8'($urandom);
      wdat[3] = 8'($urandom);
      write_regs(ccs_pkg::WR_ADDR, 4);
      host_halt_n = 1'($urandom);
      bus_halt_n = 1'($urandom);
      check_act();
      read_regs(4);
    end
    write_regs(8'hD0, 3);
    write_regs(8'h52, 3);
    read_regs(3);
    reset(1'b1);
    host_halt_n = 1'b0;
    bus_halt_n = 1'b0;
    check_act();
    give_verdict();
  end

  // Watchdog, well beyond the expected run length
  initial
  begin
    repeat (80000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
endmodule
